// [sec_eeprom.sv]
// Serial EEPROM command engine: link-side decoder and core-side programmer.
// Assumes serial_clock and chip_select come from the host, unrelated to clk.
`timescale 1ns/10ps

module sec_eeprom
  import sec_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
)(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic serial_clock,
  input  wire logic chip_select,
  input  wire logic data_in,
  output logic      data_out,
  output logic      data_out_oe
);

  sec_lnk_t  lnk_r;
  sec_lnk_t  lnk_nxt;
  sec_hold_t hold_r;
  sec_hold_t hold_nxt;
  sec_core_t core_r;
  sec_core_t core_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: shift and decode on rising serial clock edges

  // Frame decoder; storage is read here while it is static
  always_comb begin
    logic [9:0] shn;
    shn      = {lnk_r.sh[8:0], data_in};
    lnk_nxt  = lnk_r;
    hold_nxt = hold_r;
    case (lnk_r.st)
      SEC_LS_IDLE: begin
        if (data_in) begin
          lnk_nxt.st    = SEC_LS_CMD;
          lnk_nxt.cnt   = 5'h00;
          hold_nxt.done = 1'b0;
        end
      end
      SEC_LS_CMD: begin
        lnk_nxt.sh  = shn;
        lnk_nxt.cnt = lnk_r.cnt + 5'h01;
        if (lnk_r.cnt[3:0] == CMD_LAST) begin
          hold_nxt.addr = shn[ADDR_W-1:0];                    // Top address bit ignored
          lnk_nxt.st    = SEC_LS_WAIT;
          case (shn[9:8])
            OP_READ: begin
              lnk_nxt.st      = SEC_LS_READ;
              lnk_nxt.raddr   = shn[ADDR_W-1:0];
              lnk_nxt.rbit    = 4'h0;
              lnk_nxt.obit    = 1'b0;                         // Leading dummy zero
              lnk_nxt.reading = 1'b1;
            end
            OP_WRITE: begin
              hold_nxt.kind = SEC_K_WRITE;
              lnk_nxt.st    = SEC_LS_DATA;
              lnk_nxt.cnt   = 5'h00;
            end
            OP_ERASE: begin
              hold_nxt.kind = SEC_K_ERASE;
              hold_nxt.done = 1'b1;
            end
            default: begin
              case (shn[7:6])
                EXT_EN: begin
                  hold_nxt.kind = SEC_K_EN;
                  hold_nxt.done = 1'b1;
                end
                EXT_WRITE_ALL_WORDS_INSTR: begin
                  hold_nxt.kind = SEC_K_WRITE_ALL_WORDS_INSTR;
                  lnk_nxt.st    = SEC_LS_DATA;
                  lnk_nxt.cnt   = 5'h00;
                end
                EXT_DIS: begin
                  hold_nxt.kind = SEC_K_DIS;
                  hold_nxt.done = 1'b1;
                end
                default: begin
                  hold_nxt.kind = SEC_K_ERASE_ALL_WORDS_INSTR;
                  hold_nxt.done = 1'b1;
                end
              endcase
            end
          endcase
        end
      end
      SEC_LS_DATA: begin
        // Keep shifting so only the last sixteen bits remain
        hold_nxt.data = {hold_r.data[WORD_W-2:0], data_in};
        if (lnk_r.cnt != DATA_BITS) begin
          lnk_nxt.cnt = lnk_r.cnt + 5'h01;
        end
        if (lnk_r.cnt >= (DATA_BITS - 5'h01)) begin
          hold_nxt.done = 1'b1;
        end
      end
      SEC_LS_READ: begin
        // MSB first, then the next word, wrapping at the top
        lnk_nxt.obit = core_r.mem[lnk_r.raddr][BIT_LAST - lnk_r.rbit];
        lnk_nxt.rbit = lnk_r.rbit + 4'h1;
        if (lnk_r.rbit == BIT_LAST) begin
          lnk_nxt.raddr = lnk_r.raddr + 7'h01;
        end
      end
      SEC_LS_WAIT: begin
        lnk_nxt.st = SEC_LS_WAIT;                             // Extra bits ignored
      end
      default: begin
        lnk_nxt.st = SEC_LS_IDLE;
      end
    endcase
  end

  // Frame state clears while select is low
  always_ff @(posedge serial_clock or negedge chip_select) begin
    if (!chip_select) begin
      lnk_r <= '0;
    end else begin
      lnk_r <= lnk_nxt;
    end
  end

  // Held command survives the select fall for the core to take
  // Reset acts at once, since the link clock may stand still in reset
  always_ff @(posedge serial_clock or posedge rst) begin
    if (rst) begin
      hold_r <= '0;
    end else if (chip_select) begin
      hold_r <= hold_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: synchronisers, enable latch, self-timed programming

  // Command start, timer and array update
  always_comb begin
    core_nxt         = core_r;
    core_nxt.cs_s1   = chip_select;
    core_nxt.cs_s2   = core_r.cs_s1;
    core_nxt.cs_d    = core_r.cs_s2;
    core_nxt.done_s1 = hold_r.done;
    core_nxt.done_s2 = core_r.done_s1;
    core_nxt.rd_s1   = {lnk_r.reading, lnk_r.obit};
    core_nxt.rd_s2   = core_r.rd_s1;
    // A finished command is taken at most once: a status-only select
    // pulse leaves the held command done and must not restart it
    if (!core_r.done_s2) begin
      core_nxt.fresh = 1'b1;
    end else if (core_r.cs_d && !core_r.cs_s2) begin
      core_nxt.fresh = 1'b0;
    end
    case (core_r.st)
      SEC_PS_IDLE: begin
        // Held fields are stable once done has crossed and select is low
        if (core_r.cs_d && !core_r.cs_s2 && core_r.done_s2 && core_r.fresh) begin
          core_nxt.kind = hold_r.kind;
          core_nxt.addr = hold_r.addr;
          core_nxt.data = hold_r.data;
          case (hold_r.kind)
            SEC_K_EN:  core_nxt.en = 1'b1;
            SEC_K_DIS: core_nxt.en = 1'b0;
            SEC_K_WRITE, SEC_K_WRITE_ALL_WORDS_INSTR, SEC_K_ERASE, SEC_K_ERASE_ALL_WORDS_INSTR: begin
              if (core_r.en) begin
                core_nxt.st    = SEC_PS_PROG;
                core_nxt.timer = TMR_W'(PROG_CYC - 1);
              end
            end
            default: core_nxt.en = core_r.en;
          endcase
        end
      end
      SEC_PS_PROG: begin
        // New frames are not looked at until the cycle ends
        // (their select fall still retires the held command)
        if (core_r.timer == '0) begin
          core_nxt.st = SEC_PS_IDLE;
          case (core_r.kind)
            SEC_K_WRITE: core_nxt.mem[core_r.addr] = core_r.data;
            SEC_K_ERASE: core_nxt.mem[core_r.addr] = ERASED_WORD;
            SEC_K_WRITE_ALL_WORDS_INSTR: begin
              for (int i = 0; i < WORDS; i++) begin
                core_nxt.mem[i] = core_r.data;
              end
            end
            SEC_K_ERASE_ALL_WORDS_INSTR: begin
              for (int i = 0; i < WORDS; i++) begin
                core_nxt.mem[i] = ERASED_WORD;
              end
            end
            default: core_nxt.st = SEC_PS_IDLE;
          endcase
        end else begin
          core_nxt.timer = core_r.timer - TMR_W'(1);
        end
      end
      default: core_nxt.st = SEC_PS_IDLE;
    endcase
    // Read bit while reading, else ready/busy status
    core_nxt.dout    = core_r.rd_s2[1] ? core_r.rd_s2[0]
                                       : (core_r.st == SEC_PS_IDLE);
    core_nxt.dout_oe = core_r.cs_s2;
  end

  // Core register; array resets to the erased pattern
  // The link side stays free of ce, so a frame is never cut by a freeze
  always_ff @(posedge clk) begin
    if (rst) begin
      core_r     <= '0;
      core_r.mem <= {WORDS{ERASED_WORD}};
    end else if (ce) begin
      core_r <= core_nxt;
    end
  end

  assign data_out    = core_r.dout;
  assign data_out_oe = core_r.dout_oe;

endmodule

// [sec_eeprom_chk.sv]
// Checker on the ports of the command engine.
// Assumes one core clock domain and a synchronous reset.
`timescale 1ns/10ps
module sec_eeprom_chk #(
  parameter int PROG_CYC = 250000
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic serial_clock,
  input wire logic chip_select,
  input wire logic data_in,
  input wire logic data_out,
  input wire logic data_out_oe
);
  logic [19:0] low_n_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Length of the current busy run on the output
  always_ff @(posedge clk) begin
    if (rst || !data_out_oe || data_out)
      low_n_r <= 20'h0;
    else if (ce)
      low_n_r <= low_n_r + 20'h1;
  end
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !data_out && !data_out_oe)
    else $error("outputs active in reset");
  a_ready_release: assert property (disable iff (1'b0) rst ##1 (!rst && ce) |=> data_out)
    else $error("not ready after reset");
  a_oe_rise: assert property ((chip_select && ce) [*4] |-> data_out_oe)
    else $error("output not driven");
  a_oe_fall: assert property ((!chip_select && ce) [*4] |-> !data_out_oe)
    else $error("output still driven");
  a_oe_rose_cause: assert property ($rose(data_out_oe) |-> $past(chip_select, 2) || $past(chip_select, 3))
    else $error("drive without select");
  a_oe_fell_cause: assert property ($fell(data_out_oe) |-> $past(rst) || !$past(chip_select, 2) || !$past(chip_select, 3))
    else $error("drive dropped early");
  a_busy_bound: assert property (low_n_r <= PROG_CYC + 8)
    else $error("busy too long");
  a_ce_freeze: assert property (!ce |=> $stable(data_out) && $stable(data_out_oe))
    else $error("output moved while frozen");
endmodule
bind sec_eeprom sec_eeprom_chk #(.PROG_CYC(PROG_CYC)) sec_eeprom_chk_i (.clk(clk), .rst(rst),
  .ce(ce), .serial_clock(serial_clock), .chip_select(chip_select), .data_in(data_in),
  .data_out(data_out), .data_out_oe(data_out_oe));

// [sec_host.sv]
// Host model driving select, serial clock and data of the device.
// Assumes read bits settle within four core clocks of a serial edge.
`timescale 1ns/10ps
module sec_host (
  output logic      serial_clock,
  output logic      chip_select,
  output logic      data_in,
  input  wire logic data_out
);
  logic [15:0] word;
  logic        lead0;
  event        got;
  initial begin
    serial_clock = 1'b0;
    chip_select  = 1'b0;
    data_in      = 1'b1;
  end
  // One bit taken on the rising edge, then lo ns of extra low time
  task automatic pulse(input logic b, input int lo);
    data_in = b;
    #40 serial_clock = 1'b1;
    #40 serial_clock = 1'b0;
    #lo;
  endtask
  // Frame sent MSB first; clock stands still outside it
  task automatic send(input logic [47:0] v, input int n, input int lo);
    chip_select = 1'b1;
    #47;
    for (int i = n - 1; i >= 0; i--)
      pulse(v[i], (i == 0) ? lo : 0);
  endtask
  // Select drops before the next rising edge; released data inverts
  task automatic close();
    data_in = ~data_in;
    chip_select = 1'b0;
    #240;
  endtask
  // Status poll; no new command until ready
  task automatic status(output logic busy, output int n);
    chip_select = 1'b1;
    #200 busy = !data_out;
    n = 0;
    while (data_out !== 1'b1 && n < 5000) begin
      #40 n++;
    end
    close();
  endtask
  // Read n words; the lead bit is kept apart
  task automatic read(input logic [7:0] a, input int n);
    send({3'b110, a}, 11, 160);
    for (int i = 0; i <= 16 * n; i++) begin
      word = {word[14:0], data_out};
      if (i == 0)
        lead0 = data_out;
      if (i > 0 && i % 16 == 0)
        -> got;
      if (i < 16 * n)
        pulse(1'b0, 160);
    end
    close();
  endtask
endmodule

// [sec_pkg.sv]
// Constants, states and carriers for the serial EEPROM command engine.
// Assumes a 25 MHz core clock and a host-driven serial clock of its own.
package sec_pkg;

  localparam int          WORDS        = 128;
  localparam int          WORD_W       = 16;
  localparam int          ADDR_W       = 7;
  localparam int          FIELD_LAST   = 9;
  localparam int          PROG_TIME_MS = 10;
  localparam int          CLK_HZ       = 25000000;
  localparam int          PROG_CYCLES  = (PROG_TIME_MS * (CLK_HZ / 1000));
  localparam int          TMR_W        = 18;
  localparam logic [4:0]  DATA_BITS    = 5'h10;
  localparam logic [3:0]  CMD_LAST     = 4'h9;
  localparam logic [3:0]  BIT_LAST     = 4'hf;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;

  // Opcode and extended-address prefixes
  localparam logic [1:0]  OP_EXT       = 2'h0;
  localparam logic [1:0]  OP_WRITE     = 2'h1;
  localparam logic [1:0]  OP_READ      = 2'h2;
  localparam logic [1:0]  OP_ERASE     = 2'h3;
  localparam logic [1:0]  EXT_DIS      = 2'h0;
  localparam logic [1:0]  EXT_WRITE_ALL_WORDS_INSTR    = 2'h1;
  localparam logic [1:0]  EXT_ERASE_ALL_WORDS_INSTR     = 2'h2;
  localparam logic [1:0]  EXT_EN       = 2'h3;

  typedef enum logic [2:0] {
    SEC_LS_IDLE = 3'h0,
    SEC_LS_CMD  = 3'h1,
    SEC_LS_DATA = 3'h3,
    SEC_LS_WAIT = 3'h2,
    SEC_LS_READ = 3'h6
  } sec_lstate_t;

  typedef enum logic [2:0] {
    SEC_K_NONE  = 3'h0,
    SEC_K_WRITE = 3'h1,
    SEC_K_WRITE_ALL_WORDS_INSTR = 3'h2,
    SEC_K_ERASE = 3'h3,
    SEC_K_ERASE_ALL_WORDS_INSTR  = 3'h4,
    SEC_K_EN    = 3'h5,
    SEC_K_DIS   = 3'h6
  } sec_kind_t;

  typedef enum logic {
    SEC_PS_IDLE = 1'b0,
    SEC_PS_PROG = 1'b1
  } sec_pstate_t;

  // Link-side frame state, cleared whenever select is low
  typedef struct packed {
    sec_lstate_t         st;
    logic [4:0]          cnt;
    logic [9:0]          sh;
    logic [ADDR_W-1:0]   raddr;
    logic [3:0]          rbit;
    logic                obit;
    logic                reading;
  } sec_lnk_t;

  // Completed command held for the core across the select fall
  typedef struct packed {
    logic                done;
    sec_kind_t           kind;
    logic [ADDR_W-1:0]   addr;
    logic [WORD_W-1:0]   data;
  } sec_hold_t;

  // Core-side state including the storage array
  typedef struct packed {
    logic                         cs_s1;
    logic                         cs_s2;
    logic                         cs_d;
    logic                         done_s1;
    logic                         done_s2;
    logic [1:0]                   rd_s1;
    logic [1:0]                   rd_s2;
    logic                         en;
    logic                         fresh;
    sec_pstate_t                  st;
    sec_kind_t                    kind;
    logic [ADDR_W-1:0]            addr;
    logic [WORD_W-1:0]            data;
    logic [TMR_W-1:0]             timer;
    logic                         dout;
    logic                         dout_oe;
    logic [WORDS-1:0][WORD_W-1:0] mem;
  } sec_core_t;

endpackage

// [serial_eeprom_command_set_test.sv]
// Testbench of the command engine with a host model on the serial side.
// Assumes a shortened programming time for simulation.
`timescale 1ns/10ps
module serial_eeprom_command_set_test;
  import sec_pkg::*;
  localparam int PC = 40;
  logic        clk, rst, ce, sck, cs, din, dout, oe, busy;
  logic [15:0] exp_q[$];
  logic [15:0] d1, d2, d3;
  int          mismatches, checks_done, wt;
  sec_eeprom #(.PROG_CYC(PC)) sec_eeprom_i (.clk(clk), .rst(rst), .ce(ce),
    .serial_clock(sck), .chip_select(cs), .data_in(din), .data_out(dout), .data_out_oe(oe));
  sec_host sec_host_i (.serial_clock(sck), .chip_select(cs), .data_in(din), .data_out(dout));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Command frame, then status poll
  task automatic prog(input logic [47:0] v, input int n, input logic eb);
    sec_host_i.send(v, n, 0);
    sec_host_i.close();
    sec_host_i.status(busy, wt);
    chk(busy === eb, "busy level");
    chk(wt <= PC + 8, "ready late");
    sec_host_i.status(busy, wt);
    chk(busy === 1'b0 && wt == 0, "command ran twice");
    chk(oe === 1'b0, "output left driven");
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    sec_host_i.read(a, n);
    chk(sec_host_i.lead0 === 1'b0, "lead bit");
  endtask
  // Oldest expected word against each word read
  always @(sec_host_i.got) begin
    chk(exp_q.size() > 0 && sec_host_i.word === exp_q[0], "read word");
    chk(oe === 1'b1, "read not driven");
    if (exp_q.size() > 0)
      void'(exp_q.pop_front());
  end
  initial begin
    #1000000;
    mismatches++;
    results();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    void'($urandom(32'haf2b347c));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    d1 = 16'($urandom()) | 16'h8181;
    d2 = 16'($urandom()) | 16'h8181;
    d3 = 16'($urandom()) | 16'h8181;
    exp_q.push_back(16'hffff);
    rd(8'h05, 1);
    prog({3'b101, 8'h03, d1}, 27, 1'b0);
    exp_q.push_back(16'hffff);
    rd(8'h03, 1);
    prog({3'b100, 8'hc5}, 11, 1'b0);
    prog({3'b101, 8'h7f, 4'ha, d1}, 31, 1'b1);
    prog({3'b101, 8'h80, d2}, 27, 1'b1);
    exp_q.push_back(d1);
    exp_q.push_back(d2);
    rd(8'h7f, 2);
    prog({3'b111, 8'hff}, 11, 1'b1);
    exp_q.push_back(16'hffff);
    exp_q.push_back(d2);
    rd(8'hff, 2);
    prog({3'b100, 8'h5a, d3}, 27, 1'b1);
    exp_q.push_back(d3);
    rd(8'h31, 1);
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    prog({3'b100, 8'hb3}, 11, 1'b1);
    exp_q.push_back(16'hffff);
    rd(8'h22, 1);
    prog({3'b100, 8'h2c}, 11, 1'b0);
    prog({3'b101, 8'h01, d1}, 27, 1'b0);
    prog({2'b00, 3'b100, 8'hc0}, 13, 1'b0);
    prog({3'b101, 8'h01, d3}, 27, 1'b1);
    exp_q.push_back(d3);
    rd(8'h01, 1);
    chk(exp_q.size() == 0, "reads missing");
    repeat (20) @(posedge clk);
    results();
  end
endmodule
